// File: hdl/cmmd_pkg.sv
// Package: region codes, map boundaries and bank sizing for the memory map decoder
package cmmd_pkg;
    localparam int CMMD_AW = 24;
    localparam int CMMD_BANK_BITS = 11;
    localparam logic [23:0] CMMD_IO_BASE = 24'hff_ff80;
    localparam logic [23:0] CMMD_SW_BASE = 24'hff_f000;
    localparam logic [23:0] CMMD_SW_LAST = 24'hff_ff7f;
    localparam logic [23:0] CMMD_ROM_BASE = 24'hff_0000;
    localparam logic [23:0] CMMD_ROM_LAST = 24'hff_efff;
    localparam logic [23:0] CMMD_INT_MAX = 24'h00_ffff;
    localparam logic [23:0] CMMD_BOOT_LAST_SMALL = 24'hff_00bf;
    localparam logic [23:0] CMMD_PROM_BASE = 24'hff_00c0;
    localparam logic [23:0] CMMD_CACHE_WORDS = 24'h00_0400;
    localparam logic [3:0] CMMD_YGRP_SHIFT = 4'h4;
    localparam logic [23:0] CMMD_XRAM_LAST_DEF = 24'h00_3fff;
    localparam logic [23:0] CMMD_YRAM_LAST_DEF = 24'h00_3fff;
    localparam logic [23:0] CMMD_PRAM_LAST_DEF = 24'h00_3fff;
    localparam logic [23:0] CMMD_CACHE_BASE_DEF = 24'h00_3c00;
    localparam logic [7:0] CMMD_YGRP_INT_DEF = 8'hff;
    localparam logic [31:0] CMMD_ROM_FIT_DEF = 32'h0000_0000;

    typedef enum logic [2:0] {
        CMMD_R_INTRAM,
        CMMD_R_PERIPH,
        CMMD_R_ROMMOD,
        CMMD_R_BOOT,
        CMMD_R_CACHE,
        CMMD_R_EXT,
        CMMD_R_DENY
    } cmmd_region_e;

    typedef enum logic [1:0] {
        CMMD_SP_P,
        CMMD_SP_X,
        CMMD_SP_Y
    } cmmd_space_e;
endpackage : cmmd_pkg

// File: hdl/cmmd_space_decode.sv
// One space's address decoder: region and bank for a single address
`timescale 1ns/1ns
module cmmd_space_decode
    import cmmd_pkg::*;
#(
    parameter cmmd_space_e SPACE = CMMD_SP_X,
    parameter logic [23:0] RAM_LAST = CMMD_XRAM_LAST_DEF,
    parameter logic [23:0] CACHE_BASE = CMMD_CACHE_BASE_DEF,
    parameter logic SW_INTERNAL = 1'b1,
    parameter logic [7:0] YGRP_INT = CMMD_YGRP_INT_DEF,
    parameter logic [23:0] BOOT_LAST = CMMD_BOOT_LAST_SMALL,
    parameter logic [31:0] ROM_FIT = CMMD_ROM_FIT_DEF
) (
    // Access
    input wire logic [23:0] i_addr,
    input wire logic i_is_dma,
    input wire logic i_cache_en,
    // Result
    output cmmd_region_e o_region,
    output logic [12:0] o_bank
);
    logic [4:0] rom_idx;
    logic [2:0] ygrp;

    always_comb begin
        rom_idx = 5'(i_addr[15:CMMD_BANK_BITS]);
        ygrp = i_addr[6:4];
        o_bank = 13'(i_addr[23:CMMD_BANK_BITS]);
        o_region = CMMD_R_EXT;
        if (SPACE != CMMD_SP_P && i_addr >= CMMD_IO_BASE) begin
            o_region = CMMD_R_PERIPH;
            if (SPACE == CMMD_SP_Y && !YGRP_INT[ygrp]) begin
                o_region = CMMD_R_EXT;
            end
        end else if (SPACE != CMMD_SP_P && i_addr >= CMMD_SW_BASE) begin
            o_region = SW_INTERNAL ? CMMD_R_PERIPH : CMMD_R_EXT;
        end else if (SPACE != CMMD_SP_P && i_addr >= CMMD_ROM_BASE) begin
            // Unfitted module slots fall through to the external port
            o_region = ROM_FIT[rom_idx] ? CMMD_R_ROMMOD : CMMD_R_EXT;
        end else if (SPACE == CMMD_SP_P && i_addr >= CMMD_ROM_BASE && i_addr <= BOOT_LAST) begin
            o_region = i_is_dma ? CMMD_R_DENY : CMMD_R_BOOT;
        end else if (SPACE == CMMD_SP_P && i_addr >= CMMD_PROM_BASE) begin
            o_region = ROM_FIT[rom_idx] ? CMMD_R_ROMMOD : CMMD_R_EXT;
        end else if (SPACE == CMMD_SP_P && i_addr >= CACHE_BASE
                     && i_addr < CACHE_BASE + CMMD_CACHE_WORDS) begin
            // Cache RAM is program RAM only while the cache is off
            o_region = i_cache_en ? CMMD_R_EXT : CMMD_R_INTRAM;
        end else if (i_addr <= RAM_LAST) begin
            o_region = CMMD_R_INTRAM;
        end else begin
            o_region = CMMD_R_EXT;
        end
    end
endmodule : cmmd_space_decode

// File: hdl/cmmd_decoder.sv
// Memory map decoder for program, X and Y spaces with core/DMA bank contention
// Contract
// - Separate X and Y spaces, parallel fetch
// - Top 128 X addresses go to peripherals
// - X FFF000-FFFF7F internal or external, build option
// - X FF0000-FFEFFF for 2048-word ROM/RAM banks
// - X 000000 to limit is internal RAM
// - Same-bank DMA stalls; core has priority
// - Top Y 128 in eight groups of 16
// - Y FFF000-FFFF7F internal or external, build option
// - Y FF0000-FFEFFF for 2048-word ROM/RAM banks
// - Y 000000 to limit is internal RAM
// - Bootstrap ROM from FF0000, small ends FF00BF
// - DMA refused in bootstrap ROM
// - P FF00C0 upward for program ROM banks
// - P 000000 to limit is internal RAM
// - External program memory follows internal directly
// - Enabled cache holds 1024 words
// - Cache off: cache RAM is program RAM
// - Cache on: range redirected to external
`timescale 1ns/1ns
module cmmd_decoder
    import cmmd_pkg::*;
#(
    // Device boundaries and build options
    parameter logic [23:0] XRAM_LAST = CMMD_XRAM_LAST_DEF,
    parameter logic [23:0] YRAM_LAST = CMMD_YRAM_LAST_DEF,
    parameter logic [23:0] PRAM_LAST = CMMD_PRAM_LAST_DEF,
    parameter logic [23:0] CACHE_BASE = CMMD_CACHE_BASE_DEF,
    parameter logic X_SW_INTERNAL = 1'b1,
    parameter logic Y_SW_INTERNAL = 1'b1,
    parameter logic [7:0] YGRP_INT = CMMD_YGRP_INT_DEF,
    parameter logic [23:0] BOOT_LAST = CMMD_BOOT_LAST_SMALL,
    parameter logic [31:0] XROM_FIT = CMMD_ROM_FIT_DEF,
    parameter logic [31:0] YROM_FIT = CMMD_ROM_FIT_DEF,
    parameter logic [31:0] PROM_FIT = CMMD_ROM_FIT_DEF
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Core status word cache-enable bit
    input wire logic i_cache_en,
    // Core X, Y and program requests
    input wire logic i_core_x_req,
    input wire logic [23:0] i_core_x_addr,
    input wire logic i_core_y_req,
    input wire logic [23:0] i_core_y_addr,
    input wire logic i_core_p_req,
    input wire logic [23:0] i_core_p_addr,
    // DMA request
    input wire logic i_dma_req,
    input wire logic [1:0] i_dma_space,
    input wire logic [23:0] i_dma_addr,
    // Core routing
    output logic o_core_x_vld,
    output cmmd_region_e o_core_x_region,
    output logic o_core_y_vld,
    output cmmd_region_e o_core_y_region,
    output logic o_core_p_vld,
    output cmmd_region_e o_core_p_region,
    // DMA routing
    output logic o_dma_grant,
    output logic o_dma_stall,
    output logic o_dma_deny,
    output cmmd_region_e o_dma_region
);
    cmmd_region_e cx_r, cy_r, cp_r, dx_r, dy_r, dp_r, d_r;
    logic [12:0] cx_b, cy_b, cp_b, dx_b, dy_b, dp_b;

    typedef struct packed {
        logic cx_vld;
        cmmd_region_e cx_reg;
        logic cy_vld;
        cmmd_region_e cy_reg;
        logic cp_vld;
        cmmd_region_e cp_reg;
        logic d_grant;
        logic d_stall;
        logic d_deny;
        cmmd_region_e d_reg;
    } cmmd_state_s;

    cmmd_state_s st_reg, st_next;
    logic conflict;

    // Banked regions only; peripherals and external have no bank conflict
    function automatic logic cmmd_banked(input cmmd_region_e r);
        return r == CMMD_R_INTRAM || r == CMMD_R_ROMMOD || r == CMMD_R_CACHE
            || r == CMMD_R_BOOT;
    endfunction : cmmd_banked

    function automatic logic cmmd_clash(input logic creq, input cmmd_region_e cr,
                                        input logic [12:0] cb, input cmmd_region_e dr,
                                        input logic [12:0] db);
        return creq && cmmd_banked(cr) && cmmd_banked(dr) && cr == dr && cb == db;
    endfunction : cmmd_clash

    // Separate X and Y decoders allow two operands per cycle
    cmmd_space_decode #(.SPACE(CMMD_SP_X), .RAM_LAST(XRAM_LAST), .CACHE_BASE(CACHE_BASE),
        .SW_INTERNAL(X_SW_INTERNAL), .YGRP_INT(YGRP_INT), .BOOT_LAST(BOOT_LAST),
        .ROM_FIT(XROM_FIT)) u_cx (
        .i_addr(i_core_x_addr), .i_is_dma(1'b0), .i_cache_en(i_cache_en),
        .o_region(cx_r), .o_bank(cx_b));
    cmmd_space_decode #(.SPACE(CMMD_SP_Y), .RAM_LAST(YRAM_LAST), .CACHE_BASE(CACHE_BASE),
        .SW_INTERNAL(Y_SW_INTERNAL), .YGRP_INT(YGRP_INT), .BOOT_LAST(BOOT_LAST),
        .ROM_FIT(YROM_FIT)) u_cy (
        .i_addr(i_core_y_addr), .i_is_dma(1'b0), .i_cache_en(i_cache_en),
        .o_region(cy_r), .o_bank(cy_b));
    cmmd_space_decode #(.SPACE(CMMD_SP_P), .RAM_LAST(PRAM_LAST), .CACHE_BASE(CACHE_BASE),
        .SW_INTERNAL(1'b0), .YGRP_INT(YGRP_INT), .BOOT_LAST(BOOT_LAST),
        .ROM_FIT(PROM_FIT)) u_cp (
        .i_addr(i_core_p_addr), .i_is_dma(1'b0), .i_cache_en(i_cache_en),
        .o_region(cp_r), .o_bank(cp_b));
    cmmd_space_decode #(.SPACE(CMMD_SP_X), .RAM_LAST(XRAM_LAST), .CACHE_BASE(CACHE_BASE),
        .SW_INTERNAL(X_SW_INTERNAL), .YGRP_INT(YGRP_INT), .BOOT_LAST(BOOT_LAST),
        .ROM_FIT(XROM_FIT)) u_dx (
        .i_addr(i_dma_addr), .i_is_dma(1'b1), .i_cache_en(i_cache_en),
        .o_region(dx_r), .o_bank(dx_b));
    cmmd_space_decode #(.SPACE(CMMD_SP_Y), .RAM_LAST(YRAM_LAST), .CACHE_BASE(CACHE_BASE),
        .SW_INTERNAL(Y_SW_INTERNAL), .YGRP_INT(YGRP_INT), .BOOT_LAST(BOOT_LAST),
        .ROM_FIT(YROM_FIT)) u_dy (
        .i_addr(i_dma_addr), .i_is_dma(1'b1), .i_cache_en(i_cache_en),
        .o_region(dy_r), .o_bank(dy_b));
    cmmd_space_decode #(.SPACE(CMMD_SP_P), .RAM_LAST(PRAM_LAST), .CACHE_BASE(CACHE_BASE),
        .SW_INTERNAL(1'b0), .YGRP_INT(YGRP_INT), .BOOT_LAST(BOOT_LAST),
        .ROM_FIT(PROM_FIT)) u_dp (
        .i_addr(i_dma_addr), .i_is_dma(1'b1), .i_cache_en(i_cache_en),
        .o_region(dp_r), .o_bank(dp_b));

    always_comb begin
        st_next = st_reg;
        d_r = CMMD_R_EXT;
        conflict = 1'b0;
        st_next.cx_vld = i_core_x_req;
        st_next.cx_reg = cx_r;
        st_next.cy_vld = i_core_y_req;
        st_next.cy_reg = cy_r;
        st_next.cp_vld = i_core_p_req;
        st_next.cp_reg = cp_r;
        if (i_dma_space == 2'(CMMD_SP_X)) begin
            d_r = dx_r;
            conflict = cmmd_clash(i_core_x_req, cx_r, cx_b, dx_r, dx_b);
        end else if (i_dma_space == 2'(CMMD_SP_Y)) begin
            d_r = dy_r;
            conflict = cmmd_clash(i_core_y_req, cy_r, cy_b, dy_r, dy_b);
        end else if (i_dma_space == 2'(CMMD_SP_P)) begin
            d_r = dp_r;
            conflict = cmmd_clash(i_core_p_req, cp_r, cp_b, dp_r, dp_b);
        end else begin
            d_r = CMMD_R_DENY;
        end
        // Core keeps the slot; DMA retries next cycle
        st_next.d_deny = i_dma_req && d_r == CMMD_R_DENY;
        st_next.d_stall = i_dma_req && !st_next.d_deny && conflict;
        st_next.d_grant = i_dma_req && !st_next.d_deny && !conflict;
        st_next.d_reg = d_r;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '{cx_vld: 1'b0, cx_reg: CMMD_R_EXT, cy_vld: 1'b0, cy_reg: CMMD_R_EXT,
                        cp_vld: 1'b0, cp_reg: CMMD_R_EXT, d_grant: 1'b0, d_stall: 1'b0,
                        d_deny: 1'b0, d_reg: CMMD_R_EXT};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_core_x_vld = st_reg.cx_vld;
    assign o_core_x_region = st_reg.cx_reg;
    assign o_core_y_vld = st_reg.cy_vld;
    assign o_core_y_region = st_reg.cy_reg;
    assign o_core_p_vld = st_reg.cp_vld;
    assign o_core_p_region = st_reg.cp_reg;
    assign o_dma_grant = st_reg.d_grant;
    assign o_dma_stall = st_reg.d_stall;
    assign o_dma_deny = st_reg.d_deny;
    assign o_dma_region = st_reg.d_reg;

    // One-edge request patterns for the DMA stall, grant and boot refusal checks
    sequence s_x_same_bank;
        i_dma_req && i_dma_space == 2'(CMMD_SP_X) && i_core_x_req
        && cx_r == CMMD_R_INTRAM && dx_r == CMMD_R_INTRAM && cx_b == dx_b;
    endsequence

    sequence s_y_same_bank;
        i_dma_req && i_dma_space == 2'(CMMD_SP_Y) && i_core_y_req
        && cy_r == CMMD_R_INTRAM && dy_r == CMMD_R_INTRAM && cy_b == dy_b;
    endsequence

    sequence s_p_same_bank;
        i_dma_req && i_dma_space == 2'(CMMD_SP_P) && i_core_p_req
        && cp_r == CMMD_R_INTRAM && dp_r == CMMD_R_INTRAM && cp_b == dp_b;
    endsequence

    sequence s_dma_alone;
        i_dma_req && !i_core_x_req && !i_core_y_req && !i_core_p_req
        && i_dma_space != 2'b11 && d_r != CMMD_R_DENY;
    endsequence

    sequence s_dma_boot;
        i_dma_req && i_dma_space == 2'(CMMD_SP_P) && i_dma_addr >= CMMD_ROM_BASE
        && i_dma_addr <= BOOT_LAST;
    endsequence

    a_dma_exclusive: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $onehot0({o_dma_grant, o_dma_stall, o_dma_deny}))
        else $error("DMA outcomes overlap");

    a_dma_stall_cause: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        s_x_same_bank |=> o_dma_stall)
        else $error("Same-bank DMA not stalled");

    a_y_stall_cause: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        s_y_same_bank |=> o_dma_stall)
        else $error("Same-bank Y DMA not stalled");

    a_p_stall_cause: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        s_p_same_bank |=> o_dma_stall)
        else $error("Same-bank P DMA not stalled");

    a_dma_free_go: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        s_dma_alone |=> o_dma_grant)
        else $error("Uncontended DMA not granted");

    a_dma_idle: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !i_dma_req |=> !(o_dma_grant || o_dma_stall || o_dma_deny))
        else $error("Idle DMA port answered");

    a_boot_dma_deny: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        s_dma_boot |=> (o_dma_deny && !o_dma_grant))
        else $error("DMA reached boot ROM");

    a_dma_bad_space: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_dma_req && i_dma_space == 2'b11) |=> o_dma_deny)
        else $error("Invalid DMA space not refused");

    a_deny_region: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        o_dma_deny |-> o_dma_region == CMMD_R_DENY)
        else $error("Refused DMA region wrong");

    a_boot_core_ok: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_p_addr >= CMMD_ROM_BASE && i_core_p_addr <= BOOT_LAST)
        |=> o_core_p_region == CMMD_R_BOOT)
        else $error("Core boot fetch misrouted");

    a_core_vld_follow: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        1'b1 |=> {o_core_x_vld, o_core_y_vld, o_core_p_vld}
        == $past({i_core_x_req, i_core_y_req, i_core_p_req}))
        else $error("Core valid not one cycle after request");

    a_x_periph_top: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_x_addr >= CMMD_IO_BASE) |=> o_core_x_region == CMMD_R_PERIPH)
        else $error("Top X not peripheral");

    a_x_switch_opt: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_x_addr >= CMMD_SW_BASE && i_core_x_addr <= CMMD_SW_LAST)
        |=> o_core_x_region == (X_SW_INTERNAL ? CMMD_R_PERIPH : CMMD_R_EXT))
        else $error("X switch region misrouted");

    a_y_switch_opt: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_y_addr >= CMMD_SW_BASE && i_core_y_addr <= CMMD_SW_LAST)
        |=> o_core_y_region == (Y_SW_INTERNAL ? CMMD_R_PERIPH : CMMD_R_EXT))
        else $error("Y switch region misrouted");

    a_y_group_sel: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_y_addr >= CMMD_IO_BASE)
        |=> o_core_y_region == (YGRP_INT[$past(i_core_y_addr[6:4])] ? CMMD_R_PERIPH
                                 : CMMD_R_EXT))
        else $error("Y group misrouted");

    a_x_ram_low: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_x_addr <= XRAM_LAST) |=> o_core_x_region == CMMD_R_INTRAM)
        else $error("Low X not internal");

    a_y_ram_low: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_y_addr <= YRAM_LAST) |=> o_core_y_region == CMMD_R_INTRAM)
        else $error("Low Y not internal");

    a_p_ram_low: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (!i_cache_en && i_core_p_addr <= PRAM_LAST) |=> o_core_p_region == CMMD_R_INTRAM)
        else $error("Low P not internal");

    a_p_ext_after: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_p_addr > PRAM_LAST && i_core_p_addr < CMMD_ROM_BASE)
        |=> o_core_p_region == CMMD_R_EXT)
        else $error("Gap after program RAM");

    a_cache_hide: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_cache_en && i_core_p_addr >= CACHE_BASE
         && i_core_p_addr < CACHE_BASE + CMMD_CACHE_WORDS)
        |=> o_core_p_region == CMMD_R_EXT)
        else $error("Cache range visible");

    a_cache_open: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (!i_cache_en && i_core_p_addr >= CACHE_BASE
         && i_core_p_addr < CACHE_BASE + CMMD_CACHE_WORDS)
        |=> o_core_p_region == CMMD_R_INTRAM)
        else $error("Cache RAM not program RAM");

    a_rom_unfit: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_x_addr >= CMMD_ROM_BASE && i_core_x_addr <= CMMD_ROM_LAST
         && !XROM_FIT[i_core_x_addr[15:11]])
        |=> o_core_x_region == CMMD_R_EXT)
        else $error("Unfitted X module not external");

    a_x_rom_fit: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_x_addr >= CMMD_ROM_BASE && i_core_x_addr <= CMMD_ROM_LAST
         && XROM_FIT[i_core_x_addr[15:11]])
        |=> o_core_x_region == CMMD_R_ROMMOD)
        else $error("Fitted X module not selected");

    a_y_rom_unfit: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_y_addr >= CMMD_ROM_BASE && i_core_y_addr <= CMMD_ROM_LAST
         && !YROM_FIT[i_core_y_addr[15:11]])
        |=> o_core_y_region == CMMD_R_EXT)
        else $error("Unfitted Y module not external");

    a_p_rom_bank: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (i_core_p_addr >= CMMD_PROM_BASE && PROM_FIT[i_core_p_addr[15:11]])
        |=> o_core_p_region == CMMD_R_ROMMOD)
        else $error("Fitted P module not selected");
endmodule : cmmd_decoder

// File: sim/cmmd_access_src.sv
// Model of the core and DMA ports that issue accesses to the decoder
`timescale 1ns/1ns
module cmmd_access_src
    import cmmd_pkg::*;
(
    // Core ports
    output logic o_x_req,
    output logic [23:0] o_x_addr,
    output logic o_y_req,
    output logic [23:0] o_y_addr,
    output logic o_p_req,
    output logic [23:0] o_p_addr,
    // DMA port
    output logic o_dma_req,
    output logic [1:0] o_dma_space,
    output logic [23:0] o_dma_addr
);
    initial begin
        {o_x_req, o_y_req, o_p_req, o_dma_req} = 4'h0;
        {o_x_addr, o_y_addr, o_p_addr, o_dma_addr} = 96'h0;
        o_dma_space = 2'h0;
    end

    task automatic core(input cmmd_space_e sp, input logic [23:0] a);
        case (sp)
            CMMD_SP_X: {o_x_req, o_x_addr} = {1'b1, a};
            CMMD_SP_Y: {o_y_req, o_y_addr} = {1'b1, a};
            default: {o_p_req, o_p_addr} = {1'b1, a};
        endcase
    endtask : core

    task automatic dma(input logic [1:0] sp, input logic [23:0] a);
        o_dma_req = 1'b1;
        o_dma_space = sp;
        o_dma_addr = a;
    endtask : dma

    // Released lines do not keep their last value
    task automatic core_off();
        {o_x_req, o_y_req, o_p_req} = 3'h0;
        o_x_addr = ~o_x_addr;
        o_y_addr = ~o_y_addr;
        o_p_addr = ~o_p_addr;
    endtask : core_off

    task automatic idle();
        core_off();
        o_dma_req = 1'b0;
        o_dma_addr = ~o_dma_addr;
        o_dma_space = ~o_dma_space;
    endtask : idle
endmodule : cmmd_access_src

// File: sim/cmmd_decoder_tb_top.sv
// Testbench for the memory map decoder: routing and core/DMA contention
`timescale 1ns/1ns
module cmmd_decoder_tb_top
    import cmmd_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic cache_en = 1'b0;
    logic xr, yr, pr, dr, xv, yv, pv, gnt, stl, dny;
    logic [23:0] xa, ya, pa, da;
    logic [1:0] ds;
    cmmd_region_e xg, yg, pg, dg;
    int n_fail = 0;
    int tests_run = 0;

    always #20 i_core_clk = ~i_core_clk;

    cmmd_access_src src (.o_x_req(xr), .o_x_addr(xa), .o_y_req(yr), .o_y_addr(ya),
        .o_p_req(pr), .o_p_addr(pa), .o_dma_req(dr), .o_dma_space(ds), .o_dma_addr(da));

    // Build with X bank 1 and P bank 0 fitted, Y switch area and top Y group off-chip
    cmmd_decoder #(.Y_SW_INTERNAL(1'b0), .YGRP_INT(8'h7f), .XROM_FIT(32'h0000_0002),
        .PROM_FIT(32'h0000_0001)) i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_cache_en(cache_en),
        .i_core_x_req(xr), .i_core_x_addr(xa), .i_core_y_req(yr), .i_core_y_addr(ya),
        .i_core_p_req(pr), .i_core_p_addr(pa), .i_dma_req(dr), .i_dma_space(ds),
        .i_dma_addr(da), .o_core_x_vld(xv), .o_core_x_region(xg), .o_core_y_vld(yv),
        .o_core_y_region(yg), .o_core_p_vld(pv), .o_core_p_region(pg),
        .o_dma_grant(gnt), .o_dma_stall(stl), .o_dma_deny(dny), .o_dma_region(dg));

    task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Drive one core access, look one cycle later
    task automatic core_case(input cmmd_space_e sp, input logic [23:0] a,
                             input cmmd_region_e er);
        logic v;
        cmmd_region_e g;
        src.core(sp, a);
        @(negedge i_core_clk);
        v = (sp == CMMD_SP_X) ? xv : (sp == CMMD_SP_Y) ? yv : pv;
        g = (sp == CMMD_SP_X) ? xg : (sp == CMMD_SP_Y) ? yg : pg;
        chk({2'h0, v}, 3'h1);
        chk(g, er);
        src.idle();
        // One idle cycle so the next call does not redrive in this time step
        @(negedge i_core_clk);
    endtask : core_case

    // Flags are grant, stall, deny; region judged on grant or refusal
    task automatic dma_case(input logic [1:0] sp, input logic [23:0] a,
                            input logic [2:0] gsd, input cmmd_region_e er);
        src.dma(sp, a);
        @(negedge i_core_clk);
        chk({gnt, stl, dny}, gsd);
        if (gsd[2] || gsd[0]) chk(dg, er);
    endtask : dma_case

    task automatic t_xmap();
        core_case(CMMD_SP_X, 24'h00_0020, CMMD_R_INTRAM);
        core_case(CMMD_SP_X, 24'h00_3fff, CMMD_R_INTRAM);
        core_case(CMMD_SP_X, 24'h00_4000, CMMD_R_EXT);
        core_case(CMMD_SP_X, 24'hff_ff80, CMMD_R_PERIPH);
        core_case(CMMD_SP_X, 24'hff_ffff, CMMD_R_PERIPH);
        core_case(CMMD_SP_X, 24'hff_f000, CMMD_R_PERIPH);
        core_case(CMMD_SP_X, 24'hff_ff7f, CMMD_R_PERIPH);
        core_case(CMMD_SP_X, 24'hff_0000, CMMD_R_EXT);
        core_case(CMMD_SP_X, 24'hff_0800, CMMD_R_ROMMOD);
        core_case(CMMD_SP_X, 24'hff_efff, CMMD_R_EXT);
        $display("t_xmap done");
    endtask : t_xmap

    task automatic t_ymap();
        core_case(CMMD_SP_Y, 24'hff_ff80, CMMD_R_PERIPH);
        core_case(CMMD_SP_Y, 24'hff_ff9f, CMMD_R_PERIPH);
        core_case(CMMD_SP_Y, 24'hff_fff0, CMMD_R_EXT);
        core_case(CMMD_SP_Y, 24'hff_f800, CMMD_R_EXT);
        core_case(CMMD_SP_Y, 24'hff_0800, CMMD_R_EXT);
        core_case(CMMD_SP_Y, 24'h00_0000, CMMD_R_INTRAM);
        core_case(CMMD_SP_Y, 24'h00_4000, CMMD_R_EXT);
        $display("t_ymap done");
    endtask : t_ymap

    task automatic t_pmap();
        core_case(CMMD_SP_P, 24'hff_0000, CMMD_R_BOOT);
        core_case(CMMD_SP_P, 24'hff_00bf, CMMD_R_BOOT);
        core_case(CMMD_SP_P, 24'hff_00c0, CMMD_R_ROMMOD);
        core_case(CMMD_SP_P, 24'hff_ffff, CMMD_R_EXT);
        core_case(CMMD_SP_P, 24'h00_0000, CMMD_R_INTRAM);
        core_case(CMMD_SP_P, 24'h00_3fff, CMMD_R_INTRAM);
        core_case(CMMD_SP_P, 24'h00_4000, CMMD_R_EXT);
        $display("t_pmap done");
    endtask : t_pmap

    task automatic t_cache();
        core_case(CMMD_SP_P, 24'h00_3c00, CMMD_R_INTRAM);
        cache_en = 1'b1;
        core_case(CMMD_SP_P, 24'h00_3c00, CMMD_R_EXT);
        core_case(CMMD_SP_P, 24'h00_3fff, CMMD_R_EXT);
        core_case(CMMD_SP_P, 24'h00_3bff, CMMD_R_INTRAM);
        cache_en = 1'b0;
        core_case(CMMD_SP_P, 24'h00_3fff, CMMD_R_INTRAM);
        $display("t_cache done");
    endtask : t_cache

    task automatic t_parallel();
        src.core(CMMD_SP_X, 24'h00_0100);
        src.core(CMMD_SP_Y, 24'h00_0100);
        @(negedge i_core_clk);
        chk({1'b0, xv, yv}, 3'h3);
        chk(yg, CMMD_R_INTRAM);
        chk(xg, CMMD_R_INTRAM);
        src.idle();
        @(negedge i_core_clk);
        $display("t_parallel done");
    endtask : t_parallel

    task automatic t_dma();
        dma_case(2'h0, 24'hff_0000, 3'b001, CMMD_R_DENY);
        dma_case(2'h0, 24'hff_00bf, 3'b001, CMMD_R_DENY);
        dma_case(2'h0, 24'hff_00c0, 3'b100, CMMD_R_ROMMOD);
        dma_case(2'h3, 24'h00_0000, 3'b001, CMMD_R_DENY);
        src.core(CMMD_SP_X, 24'h00_0020);
        dma_case(2'h1, 24'h00_0010, 3'b010, CMMD_R_EXT);
        src.core_off();
        // Stalled DMA holds its request and retries
        dma_case(2'h1, 24'h00_0010, 3'b100, CMMD_R_INTRAM);
        src.core(CMMD_SP_X, 24'h00_0020);
        dma_case(2'h1, 24'h00_0800, 3'b100, CMMD_R_INTRAM);
        src.core(CMMD_SP_X, 24'h00_0020);
        dma_case(2'h2, 24'h00_0010, 3'b100, CMMD_R_INTRAM);
        src.core(CMMD_SP_Y, 24'h00_0030);
        dma_case(2'h2, 24'h00_0040, 3'b010, CMMD_R_INTRAM);
        src.core(CMMD_SP_P, 24'h00_0100);
        dma_case(2'h0, 24'h00_0200, 3'b010, CMMD_R_INTRAM);
        src.idle();
        $display("t_dma done");
    endtask : t_dma

    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (16) @(negedge i_core_clk);
        src.core(CMMD_SP_X, 24'h00_0020);
        src.dma(2'h1, 24'h00_0800);
        @(negedge i_core_clk);
        chk({xv, gnt, stl}, 3'h0);
        chk({yv, pv, dny}, 3'h0);
        chk(xg, CMMD_R_EXT);
        src.idle();
        i_rst = 1'b0;
        @(negedge i_core_clk);
        $display("t_reset done");
        t_xmap();
        t_ymap();
        t_pmap();
        t_cache();
        t_parallel();
        t_dma();
        results();
    end

    // About 90 cycles of work; a hang is cut well beyond that
    initial begin
        repeat (1000) @(posedge i_core_clk);
        n_fail++;
        results();
    end
endmodule : cmmd_decoder_tb_top
